// >>> rtl/tbarm_top.v
// timebase selection and time-interval start/stop arming, AXI4-Lite slave
// assumes ref_in_i, ext_arm_i and the event pins are asynchronous pins
// What this block does
// - reference query gives Hz, 1..10 MHz
// - unknown external frequency, auto off: NaN
// - internal timebase active: query gives NaN
// - timebase source internal or external reference
// - writing timebase source clears auto select
// - auto on: source read shows chosen timebase
// - auto picks external only at 1/5/10 MHz
// - auto enable reads '0'/'1', resets on
// - save and recall leave timebase settings alone
// - single layer: start imm/ext, stop imm/timer
// - start resets immediate, slope rising_edge_polarity, external only
// - stop source only for plain time interval
// - delay ranges: 0.01 ms short, 1 ms long
// - delay resets 10 ms, used with timer only
// - older units raise the short minimum
// - two layer: outer and inner sources each
// - immediate outer start forces immediate inner start
// - pulse functions use only the outer start
// - reference frequency answer also as six-digit ascii float
// - start event count 1..99999999, resets 1
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "tbarm_defs.vh"
module tbarm_top #(
  parameter integer WIN_CYC = `TBARM_WIN_CYC,
  parameter [19:0]  DLY_MIN = `TBARM_DLY_MIN_NEW
) (
  input  wire        core_clk_i,
  input  wire        rst_b_i,
  input  wire [5:0]  s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output reg         s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output reg         s_axi_wready_o,
  output reg  [1:0]  s_axi_bresp_o,
  output reg         s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [5:0]  s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output reg         s_axi_arready_o,
  output reg  [31:0] s_axi_rdata_o,
  output reg  [1:0]  s_axi_rresp_o,
  output reg         s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  input  wire        ref_in_i,
  input  wire        ext_arm_i,
  input  wire        start_evt_i,
  input  wire        stop_evt_i,
  output reg         tb_ext_o,
  output reg         start_arm_o,
  output reg         stop_arm_o,
  output reg         busy_o
);
  localparam [5:0] S_IDLE = 6'h01, S_OUT1 = 6'h02, S_DLY1 = 6'h04,
                   S_OUT2 = 6'h08, S_DLY2 = 6'h10, S_DONE = 6'h20;

  // pin synchronisers; stage one feeds stage two only
  reg  [3:0]  sy1_r;
  reg  [3:0]  sy2_r;
  reg  [3:0]  sy3_r;
  wire        ref_rise  = sy2_r[0] & ~sy3_r[0];
  wire        arm_rise  = sy2_r[1] & ~sy3_r[1];
  wire        arm_fall  = ~sy2_r[1] & sy3_r[1];
  wire        sevt_rise = sy2_r[2] & ~sy3_r[2];
  wire        pevt_rise = sy2_r[3] & ~sy3_r[3];

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sy1_r <= 4'h0;
      sy2_r <= 4'h0;
      sy3_r <= 4'h0;
    end else begin
      sy1_r <= {stop_evt_i, start_evt_i, ext_arm_i, ref_in_i};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end

  // reference frequency classification over a fixed window
  reg  [31:0] win_cnt_r;
  reg  [10:0] edg_cnt_r;
  reg  [1:0]  ref_cls_r;   // 0 none/invalid, 1 = 1 MHz, 2 = 5 MHz, 3 = 10 MHz
  wire [10:0] edg_hi  = edg_cnt_r + `TBARM_EDG_TOL;
  wire [10:0] edg_lo  = edg_cnt_r - `TBARM_EDG_TOL;
  wire        in_1m   = (edg_hi >= `TBARM_EDG_1M) && (edg_lo <= `TBARM_EDG_1M);
  wire        in_5m   = (edg_hi >= `TBARM_EDG_5M) && (edg_lo <= `TBARM_EDG_5M);
  wire        in_10m  = (edg_hi >= `TBARM_EDG_10M) && (edg_lo <= `TBARM_EDG_10M);
  wire [1:0]  cls_nxt = in_1m ? 2'h1 : (in_5m ? 2'h2 : (in_10m ? 2'h3 : 2'h0));

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      win_cnt_r <= 32'h0;
      edg_cnt_r <= 11'h0;
      ref_cls_r <= 2'h0;
    end else if (win_cnt_r == WIN_CYC - 1) begin
      win_cnt_r <= 32'h0;
      edg_cnt_r <= {10'h0, ref_rise};
      ref_cls_r <= cls_nxt;
    end else begin
      win_cnt_r <= win_cnt_r + 32'h1;
      if (ref_rise && edg_cnt_r != 11'h7FF)
        edg_cnt_r <= edg_cnt_r + 11'h1;
    end
  end

  // software state
  reg         src_ext_r;
  reg         auto_r;
  reg  [12:0] cfg_r;
  reg  [12:0] cfg_save_r;
  reg  [19:0] dly_r;
  reg  [26:0] secnt_r;
  reg  [26:0] pecnt_r;
  reg  [5:0]  st_r;

  wire        ref_ok  = (ref_cls_r != 2'h0);
  wire        act_ext = auto_r ? ref_ok : src_ext_r;
  wire        known   = act_ext & ref_ok;
  reg  [31:0] ref_hz;
  reg  [95:0] ref_txt;

  always @* begin
    ref_hz  = `TBARM_NAN_HZ;
    ref_txt = "9.91000E+37 ";
    if (known) begin
      case (ref_cls_r)
        2'h1: begin
          ref_hz  = 32'h000F4240;
          ref_txt = "1.00000E+06 ";
        end
        2'h2: begin
          ref_hz  = 32'h004C4B40;
          ref_txt = "5.00000E+06 ";
        end
        default: begin
          ref_hz  = 32'h00989680;
          ref_txt = "1.00000E+07 ";
        end
      endcase
    end
  end

  function [31:0] rd_mux;
    input [5:0] a;
    begin
      case (a)
        `TBARM_TB_SRC:     rd_mux = {31'h0, act_ext};
        `TBARM_TB_AUTO:    rd_mux = auto_r ? 32'h00000031 : 32'h00000030;
        `TBARM_REF_HZ:     rd_mux = ref_hz;
        `TBARM_REF_TXT0:   rd_mux = ref_txt[95:64];
        `TBARM_REF_TXT1:   rd_mux = ref_txt[63:32];
        `TBARM_REF_TXT2:   rd_mux = ref_txt[31:0];
        `TBARM_ARM_CFG:    rd_mux = {19'h0, cfg_r};
        `TBARM_STOP_DLY:   rd_mux = {12'h0, dly_r};
        `TBARM_START_ECNT: rd_mux = {5'h0, secnt_r};
        `TBARM_STOP_ECNT:  rd_mux = {5'h0, pecnt_r};
        `TBARM_STATUS:     rd_mux = {26'h0, ref_cls_r, ref_ok, act_ext, auto_r, busy_o};
        default:           rd_mux = 32'h0;
      endcase
    end
  endfunction

  // AXI4-Lite write path: address and data captured in either order
  reg         aw_hold_r;
  reg         w_hold_r;
  reg  [5:0]  aw_addr_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  wire        wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid_o;
  wire        wr_map = (aw_addr_r[1:0] == 2'h0) && (aw_addr_r <= `TBARM_CMD);
  wire        rd_map = (s_axi_araddr_i[1:0] == 2'h0) && (s_axi_araddr_i <= `TBARM_CMD);
  reg  [31:0] wmask;
  reg  [31:0] wval;
  reg  [19:0] dly_nxt;
  reg  [26:0] ecnt_a;
  reg  [26:0] ecnt_b;
  reg  [12:0] cfg_nxt;

  always @* begin
    wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wval  = (rd_mux(aw_addr_r) & ~wmask) | (w_data_r & wmask);
    // clamp to range, long range truncated to 1 ms steps
    if (wval[31:20] == 12'h0 && wval[19:0] < DLY_MIN)
      dly_nxt = DLY_MIN;
    else if (wval[31:20] != 12'h0 || wval[19:0] > `TBARM_DLY_MAX)
      dly_nxt = `TBARM_DLY_MAX;
    else if (wval[19:0] >= `TBARM_DLY_LONG)
      dly_nxt = wval[19:0] - (wval[19:0] % `TBARM_DLY_LSTEP);
    else
      dly_nxt = wval[19:0];
    ecnt_a = (wval[26:0] == 27'h0) ? 27'h1 : wval[26:0];
    ecnt_b = (wval[31:27] != 5'h0 || ecnt_a > `TBARM_ECNT_MAX) ? `TBARM_ECNT_MAX : ecnt_a;
    cfg_nxt = wval[12:0];
    if (cfg_nxt[`TBARM_CF_IN1_LO+1 -: 2] == 2'h3)
      cfg_nxt[`TBARM_CF_IN1_LO+1 -: 2] = `TBARM_IN_IMM;
    if (cfg_nxt[`TBARM_CF_IN2_LO+1 -: 2] == 2'h3)
      cfg_nxt[`TBARM_CF_IN2_LO+1 -: 2] = `TBARM_IN_IMM;
    if (!cfg_nxt[`TBARM_CF_START_EXT])
      cfg_nxt[`TBARM_CF_IN1_LO+1 -: 2] = `TBARM_IN_IMM;
  end
  wire        meas_go = wr_go && aw_addr_r == `TBARM_CMD && w_strb_r[0] && w_data_r[2];
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_hold_r       <= 1'b0;
      w_hold_r        <= 1'b0;
      aw_addr_r       <= 6'h0;
      w_data_r        <= 32'h0;
      w_strb_r        <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= 2'h0;
      src_ext_r       <= 1'b0;
      auto_r          <= `TBARM_RST_AUTO;
      cfg_r           <= `TBARM_RST_CFG;
      cfg_save_r      <= `TBARM_RST_CFG;
      dly_r           <= `TBARM_RST_DLY;
      secnt_r         <= `TBARM_RST_ECNT;
      pecnt_r         <= `TBARM_RST_ECNT;
    end else begin
      s_axi_awready_o <= ~aw_hold_r & ~s_axi_awready_o & s_axi_awvalid_i;
      s_axi_wready_o  <= ~w_hold_r & ~s_axi_wready_o & s_axi_wvalid_i;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
      end
      if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
      if (wr_go) begin
        aw_hold_r      <= 1'b0;
        w_hold_r       <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_map ? 2'h0 : 2'h3;
        case (aw_addr_r)
          `TBARM_TB_SRC: begin
            src_ext_r <= wval[0];
            auto_r    <= 1'b0;
          end
          `TBARM_TB_AUTO: auto_r <= wval[0];
          `TBARM_ARM_CFG: begin
            if (st_r == S_IDLE)
              cfg_r <= cfg_nxt;
          end
          `TBARM_STOP_DLY:   dly_r   <= dly_nxt;
          `TBARM_START_ECNT: secnt_r <= ecnt_b;
          `TBARM_STOP_ECNT:  pecnt_r <= ecnt_b;
          `TBARM_CMD: begin
            // save/recall cover arm setup only; timebase state untouched
            if (w_strb_r[0] && w_data_r[0])
              cfg_save_r <= cfg_r;
            if (w_strb_r[0] && w_data_r[1] && st_r == S_IDLE)
              cfg_r <= cfg_save_r;
          end
          default: ;
        endcase
      end
    end
  end

  // AXI4-Lite read path, answer one cycle after acceptance
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0;
      s_axi_rresp_o   <= 2'h0;
    end else begin
      s_axi_arready_o <= ~s_axi_arready_o & ~s_axi_rvalid_o & s_axi_arvalid_i;
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o  <= rd_mux(s_axi_araddr_i);
        s_axi_rresp_o  <= rd_map ? 2'h0 : 2'h3;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // effective arm plan, frozen at measurement start
  wire        two   = cfg_r[`TBARM_CF_TWO_LAYER];
  wire        is_ti = cfg_r[`TBARM_CF_FUNC_LO+2 -: 3] == `TBARM_FN_TI;
  reg  [1:0]  in1_r;
  reg  [1:0]  in2_r;
  reg         out1_r;
  reg         out2_r;
  reg         neg1_r;
  reg         neg2_r;
  reg         run_ext_r;
  reg  [9:0]  tick_len_r;
  reg  [9:0]  pre_r;
  reg  [26:0] cnt_r;
  wire        tick = (pre_r == tick_len_r - 10'h1) && (run_ext_r ? ref_rise : 1'b1);
  wire        edg1 = neg1_r ? arm_fall : arm_rise;
  wire        edg2 = neg2_r ? arm_fall : arm_rise;
  reg  [1:0]  st_in1;
  reg  [1:0]  st_in2;

  always @* begin
    st_in1 = two ? cfg_r[`TBARM_CF_IN1_LO+1 -: 2] : `TBARM_IN_IMM;
    st_in2 = two ? cfg_r[`TBARM_CF_IN2_LO+1 -: 2]
                 : (cfg_r[`TBARM_CF_STOP_TIM] ? `TBARM_IN_TIM : `TBARM_IN_IMM);
    if (!is_ti) begin
      st_in1 = `TBARM_IN_IMM;
      st_in2 = `TBARM_IN_IMM;
    end
  end
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r        <= S_IDLE;
      in1_r       <= 2'h0;
      in2_r       <= 2'h0;
      out1_r      <= 1'b0;
      out2_r      <= 1'b0;
      neg1_r      <= 1'b0;
      neg2_r      <= 1'b0;
      run_ext_r   <= 1'b0;
      tick_len_r  <= `TBARM_TICK_INT;
      pre_r       <= 10'h0;
      cnt_r       <= 27'h0;
      start_arm_o <= 1'b0;
      stop_arm_o  <= 1'b0;
      busy_o      <= 1'b0;
      tb_ext_o    <= 1'b0;
    end else begin
      start_arm_o <= 1'b0;
      stop_arm_o  <= 1'b0;
      busy_o      <= (st_r != S_IDLE);
      if (st_r == S_IDLE)
        tb_ext_o <= act_ext;
      if (tick || st_r == S_IDLE)
        pre_r <= 10'h0;
      else if (!run_ext_r || ref_rise)
        pre_r <= pre_r + 10'h1;
      case (st_r)
        S_IDLE: begin
          if (meas_go) begin
            in1_r     <= st_in1;
            in2_r     <= st_in2;
            out1_r    <= cfg_r[`TBARM_CF_START_EXT];
            out2_r    <= two & is_ti & cfg_r[`TBARM_CF_STOP_EXT];
            neg1_r    <= cfg_r[`TBARM_CF_START_NEG];
            neg2_r    <= cfg_r[`TBARM_CF_STOP_NEG];
            // timebase latched here so a switch applies to the next run
            run_ext_r <= act_ext;
            case (ref_cls_r)
              2'h1:    tick_len_r <= act_ext ? `TBARM_TICK_1M : `TBARM_TICK_INT;
              2'h2:    tick_len_r <= act_ext ? `TBARM_TICK_5M : `TBARM_TICK_INT;
              default: tick_len_r <= act_ext ? `TBARM_TICK_10M : `TBARM_TICK_INT;
            endcase
            st_r <= S_OUT1;
          end
        end
        S_OUT1: begin
          if (!out1_r || edg1) begin
            cnt_r <= (in1_r == `TBARM_IN_EVT) ? secnt_r : {7'h0, dly_r};
            st_r  <= S_DLY1;
          end
        end
        S_DLY1: begin
          if (in1_r == `TBARM_IN_IMM || cnt_r <= 27'h1 &&
              (in1_r == `TBARM_IN_TIM ? tick : sevt_rise)) begin
            start_arm_o <= 1'b1;
            st_r        <= S_OUT2;
          end else if (in1_r == `TBARM_IN_TIM ? tick : sevt_rise) begin
            cnt_r <= cnt_r - 27'h1;
          end
        end
        S_OUT2: begin
          if (!out2_r || edg2) begin
            cnt_r <= (in2_r == `TBARM_IN_EVT) ? pecnt_r : {7'h0, dly_r};
            st_r  <= S_DLY2;
          end
        end
        S_DLY2: begin
          if (in2_r == `TBARM_IN_IMM || cnt_r <= 27'h1 &&
              (in2_r == `TBARM_IN_TIM ? tick : pevt_rise)) begin
            stop_arm_o <= 1'b1;
            st_r       <= S_DONE;
          end else if (in2_r == `TBARM_IN_TIM ? tick : pevt_rise) begin
            cnt_r <= cnt_r - 27'h1;
          end
        end
        S_DONE:  st_r <= S_IDLE;
        default: st_r <= S_IDLE;
      endcase
    end
  end

endmodule // tbarm_top

// >>> rtl/tbarm_defs.vh
// constants for the timebase select and interval arming block
// assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus
`ifndef TBARM_DEFS_VH
`define TBARM_DEFS_VH
// register byte offsets
`define TBARM_TB_SRC      6'h00
`define TBARM_TB_AUTO     6'h04
`define TBARM_REF_HZ      6'h08
`define TBARM_REF_TXT0    6'h0C
`define TBARM_REF_TXT1    6'h10
`define TBARM_REF_TXT2    6'h14
`define TBARM_ARM_CFG     6'h18
`define TBARM_STOP_DLY    6'h1C
`define TBARM_START_ECNT  6'h20
`define TBARM_STOP_ECNT   6'h24
`define TBARM_STATUS      6'h28
`define TBARM_CMD         6'h2C
// arm config fields
`define TBARM_CF_TWO_LAYER 0
`define TBARM_CF_START_EXT 1
`define TBARM_CF_START_NEG 2
`define TBARM_CF_STOP_TIM  3
`define TBARM_CF_IN1_LO    4
`define TBARM_CF_STOP_EXT  6
`define TBARM_CF_STOP_NEG  7
`define TBARM_CF_IN2_LO    8
`define TBARM_CF_FUNC_LO   10
`define TBARM_CF_W         13
// inner source codes and function codes
`define TBARM_IN_IMM      2'h0
`define TBARM_IN_TIM      2'h1
`define TBARM_IN_EVT      2'h2
`define TBARM_FN_TI       3'h0
// reset values
`define TBARM_RST_AUTO    1'b1
`define TBARM_RST_CFG     13'h0000
`define TBARM_RST_DLY     20'h003E8
`define TBARM_RST_ECNT    27'h0000001
// stop delay in 10 us units: short up to 99.99 ms, long 100 ms..10 s in 1 ms steps
`define TBARM_DLY_LONG    20'h02710
`define TBARM_DLY_MAX     20'hF4240
`define TBARM_DLY_LSTEP   20'h00064
`define TBARM_DLY_MIN_NEW 20'h0000A
`define TBARM_ECNT_MAX    27'h5F5E0FF
// reference frequency measurement, 100 us window
`define TBARM_CLK_HZ      100000000
`define TBARM_WIN_NS      100000
`define TBARM_WIN_CYC     ((`TBARM_WIN_NS / 10) * (`TBARM_CLK_HZ / 100000000))
`define TBARM_EDG_1M      11'd100
`define TBARM_EDG_5M      11'd500
`define TBARM_EDG_10M     11'd1000
`define TBARM_EDG_TOL     11'd2
// per 10 us delay tick: core clocks on the internal timebase, reference edges on the external one
`define TBARM_TICK_INT    10'd1000
`define TBARM_TICK_1M     10'd10
`define TBARM_TICK_5M     10'd50
`define TBARM_TICK_10M    10'd100
`define TBARM_NAN_HZ      32'hFFFFFFFF
`endif

// >>> test/tbarm_top_assertions.sv
// checker for the arming block: bus answers, readback relations, arm pulses
// assumes it is bound onto tbarm_top with one core clock domain
`timescale 1ns/10ps
`include "tbarm_defs.vh"
module tbarm_chk (
  input wire        core_clk_i,
  input wire        rst_b_i,
  input wire [5:0]  s_axi_araddr_i,
  input wire        s_axi_arvalid_i,
  input wire        s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire [1:0]  s_axi_rresp_o,
  input wire        s_axi_rvalid_o,
  input wire        s_axi_rready_i,
  input wire        s_axi_awvalid_i,
  input wire        s_axi_awready_o,
  input wire        s_axi_bvalid_o,
  input wire        s_axi_bready_i,
  input wire        tb_ext_o,
  input wire        start_arm_o,
  input wire        stop_arm_o,
  input wire        busy_o
);
  reg [5:0] rd_addr_r;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // the read address is only visible while arvalid is up, so keep it
  always @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i) rd_addr_r <= 6'h00;
    else if (s_axi_arvalid_i && s_axi_arready_o) rd_addr_r <= s_axi_araddr_i;
  a_rd_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read answer dropped");
  a_wr_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write answer dropped");
  a_ar_take: assert property (s_axi_arvalid_i && !s_axi_arready_o |=> s_axi_arready_o)
    else $error("read address not taken");
  a_aw_take: assert property (s_axi_awvalid_i && !s_axi_awready_o |=> s_axi_awready_o)
    else $error("write address not taken");
  a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_decode_err: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > 6'h2C
    |=> s_axi_rresp_o == 2'b11) else $error("unmapped read not refused");
  a_src_shows: assert property (
    s_axi_rvalid_o && rd_addr_r == `TBARM_TB_SRC |-> s_axi_rdata_o[0] == tb_ext_o)
    else $error("source readback differs from timebase in use");
  a_nan_int: assert property (
    s_axi_rvalid_o && rd_addr_r == `TBARM_REF_HZ && !tb_ext_o
    |-> s_axi_rdata_o == `TBARM_NAN_HZ) else $error("internal timebase gave a frequency");
  a_auto_char: assert property (
    s_axi_rvalid_o && rd_addr_r == `TBARM_TB_AUTO
    |-> s_axi_rdata_o == 32'h30 || s_axi_rdata_o == 32'h31) else $error("auto flag not a digit");
  a_start_pulse: assert property (start_arm_o |-> busy_o ##1 !start_arm_o)
    else $error("start arm not a single pulse");
  a_stop_end: assert property (stop_arm_o |=> !stop_arm_o ##[0:1] !busy_o)
    else $error("busy outlived the stop arm");
endmodule // tbarm_chk

bind tbarm_top tbarm_chk u_chk (.core_clk_i, .rst_b_i, .s_axi_araddr_i, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_bvalid_o, .s_axi_bready_i, .tb_ext_o,
  .start_arm_o, .stop_arm_o, .busy_o);

// >>> test/tbarm_partner.sv
// rear-pin sources: reference oscillator and external arm line
// assumes the bench sets the half period in ns; 0 leaves the input still and low
`timescale 1ns/10ps
module tbarm_partner (
  input  wire [15:0] half_ns_i,
  input  wire        arm_lvl_i,
  output reg         ref_o,
  output wire        arm_o
);
  // free-running phase, unrelated to the core clock
  initial begin
    ref_o = 1'b0;
    forever begin
      if (half_ns_i == 16'h0000) begin
        ref_o = 1'b0;
        #7;
      end else begin
        #(half_ns_i);
        ref_o = ~ref_o;
      end
    end
  end
  assign arm_o = arm_lvl_i;
endmodule // tbarm_partner

// >>> test/tbarm_top_test.sv
// self-checking bench for tbarm_top over AXI4-Lite
// assumes the rear pins come from tbarm_partner and a 100 MHz core clock
`timescale 1ns/10ps
`include "tbarm_defs.vh"
module tbarm_top_test;
  reg         core_clk_i, rst_b_i, awvalid, wvalid, bready, arvalid, rready, arm_lvl, stop_evt;
  reg  [5:0]  awaddr, araddr;
  reg  [31:0] wdata, v;
  reg  [15:0] half_ns;
  reg  [1:0]  r;
  reg         start_evt;
  wire        awready, wready, bvalid, arready, rvalid, ref_in, ext_arm;
  wire        tb_ext, start_arm, stop_arm, busy;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     error_cnt, comparisons, cyc, t_start, t_stop, n_start, n_stop, i, k;

  tbarm_top #(.WIN_CYC(10000), .DLY_MIN(20'h0000A)) dut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ref_in_i(ref_in),
    .ext_arm_i(ext_arm), .start_evt_i(start_evt), .stop_evt_i(stop_evt), .tb_ext_o(tb_ext),
    .start_arm_o(start_arm), .stop_arm_o(stop_arm), .busy_o(busy));
  tbarm_partner ptn (.half_ns_i(half_ns), .arm_lvl_i(arm_lvl), .ref_o(ref_in), .arm_o(ext_arm));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task end_sim;
    begin
      $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  // arm pulses are logged by cycle so gaps can be measured afterwards
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (start_arm) begin t_start <= cyc; n_start <= n_start + 1; end
    if (stop_arm) begin t_stop <= cyc; n_stop <= n_stop + 1; end
    if (cyc == 90000) begin error_cnt = error_cnt + 1; end_sim; end
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task chk_rng(input integer g, input integer lo, input integer hi);
    begin
      comparisons = comparisons + 1;
      if (g < lo || g > hi) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: gap %0d outside %0d..%0d", $time, g, lo, hi);
      end
    end
  endtask

  task wr(input [5:0] a, input [31:0] d);
    reg ad, wd;
    begin
      @(posedge core_clk_i);
      ad = 1'b0;
      wd = 1'b0;
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (!(ad && wd)) begin
        @(posedge core_clk_i);
        if (awready) begin ad = 1'b1; awvalid <= 1'b0; end
        if (wready) begin wd = 1'b1; wvalid <= 1'b0; end
      end
      while (!bvalid) @(posedge core_clk_i);
      r = bresp;
      bready <= 1'b0;
    end
  endtask

  task rd(input [5:0] a);
    begin
      @(posedge core_clk_i);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      @(posedge core_clk_i);
      while (!arready) @(posedge core_clk_i);
      arvalid <= 1'b0;
      @(posedge core_clk_i);
      while (!rvalid) @(posedge core_clk_i);
      v = rdata;
      r = rresp;
      rready <= 1'b0;
    end
  endtask

  task rc(input [5:0] a, input [31:0] exp);
    begin rd(a); chk(v, exp); end
  endtask

  task wrc(input [5:0] a, input [31:0] d, input [31:0] exp);
    begin wr(a, d); chk({30'h0, r}, 32'h0); rc(a, exp); end
  endtask

  // start a measurement and wait, bounded, for its stop arm
  task arm_run;
    integer n, j;
    begin
      n = n_stop;
      j = 0;
      wr(`TBARM_CMD, 32'h4);
      while (n_stop == n && j < 30000) begin @(posedge core_clk_i); j = j + 1; end
      chk(n_stop, n + 1);
      repeat (4) @(posedge core_clk_i);
    end
  endtask

  task evt;
    begin
      // both event pins pulse; only the selected inner source listens
      @(posedge core_clk_i) stop_evt <= 1'b1;
      start_evt <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      stop_evt <= 1'b0;
      start_evt <= 1'b0;
      repeat (4) @(posedge core_clk_i);
    end
  endtask

  initial begin
    rst_b_i = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; arm_lvl = 0; stop_evt = 0; half_ns = 0;
    error_cnt = 0; comparisons = 0; cyc = 0; n_start = 0; n_stop = 0; t_start = 0; t_stop = 0;
    start_evt = 0;
    repeat (4) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    rc(`TBARM_TB_AUTO, 32'h31);
    rc(`TBARM_STOP_DLY, 32'd1000);
    rc(`TBARM_START_ECNT, 32'd1);
    rc(`TBARM_ARM_CFG, 32'h0);
    rd(6'h30);
    chk({30'h0, r}, 32'h3);
    wr(6'h30, 32'h0);
    chk({30'h0, r}, 32'h3);
    rc(`TBARM_TB_SRC, 32'h0);
    rc(`TBARM_REF_HZ, `TBARM_NAN_HZ);
    rc(`TBARM_REF_TXT0, 32'h392E3931);
    rc(`TBARM_REF_TXT2, 32'h2B333720);
    half_ns <= 16'd50;
    repeat (25000) @(posedge core_clk_i);
    rc(`TBARM_TB_SRC, 32'h1);
    chk({31'h0, tb_ext}, 32'h1);
    rc(`TBARM_REF_HZ, 32'd10000000);
    rc(`TBARM_REF_TXT0, 32'h312E3030);
    rc(`TBARM_REF_TXT1, 32'h30303045);
    rc(`TBARM_REF_TXT2, 32'h2B303720);
    wr(`TBARM_CMD, 32'h2);
    rc(`TBARM_TB_AUTO, 32'h31);
    half_ns <= 16'd167;
    repeat (25000) @(posedge core_clk_i);
    rc(`TBARM_TB_SRC, 32'h0);
    wr(`TBARM_TB_SRC, 32'h1);
    rc(`TBARM_TB_AUTO, 32'h30);
    rc(`TBARM_REF_HZ, `TBARM_NAN_HZ);
    rc(`TBARM_TB_SRC, 32'h1);
    wr(`TBARM_TB_SRC, 32'h0);
    rc(`TBARM_REF_HZ, `TBARM_NAN_HZ);
    chk({31'h0, tb_ext}, 32'h0);
    half_ns <= 16'd0;
    wrc(`TBARM_STOP_DLY, 32'd5, 32'd10);
    wrc(`TBARM_STOP_DLY, 32'd9999, 32'd9999);
    wrc(`TBARM_STOP_DLY, 32'd12345, 32'd12300);
    wrc(`TBARM_STOP_DLY, 32'd2000000, 32'd1000000);
    wrc(`TBARM_START_ECNT, 32'd0, 32'd1);
    wrc(`TBARM_START_ECNT, 32'd100000000, 32'd99999999);
    wrc(`TBARM_ARM_CFG, 32'h11, 32'h01);
    wrc(`TBARM_ARM_CFG, 32'h153, 32'h153);
    wr(`TBARM_ARM_CFG, 32'h0);
    arm_run;
    chk_rng(t_stop - t_start, 2, 2);
    wr(`TBARM_STOP_DLY, 32'd10);
    wr(`TBARM_ARM_CFG, 32'h8);
    arm_run;
    chk_rng(t_stop - t_start, 9990, 10010);
    // the stop timer must be ignored by every pulse-shape function
    for (i = 1; i < 5; i = i + 1) begin
      wr(`TBARM_ARM_CFG, 32'h8 | (i << 10));
      arm_run;
      chk_rng(t_stop - t_start, 2, 2);
    end
    for (i = 0; i < 2; i = i + 1) begin
      arm_lvl <= i[0];
      wr(`TBARM_ARM_CFG, 32'h2 | (i << 2));
      k = n_start;
      wr(`TBARM_CMD, 32'h4);
      repeat (40) @(posedge core_clk_i);
      chk(n_start, k);
      chk({31'h0, busy}, 32'h1);
      arm_lvl <= ~i[0];
      repeat (20) @(posedge core_clk_i);
      chk(n_start, k + 1);
      repeat (10) @(posedge core_clk_i);
    end
    // two layers: external start, start event count, external outer stop
    wr(`TBARM_START_ECNT, 32'd2);
    // one write sets outer start, inner start, outer stop, inner stop together
    wr(`TBARM_ARM_CFG, 32'h63);
    k = n_start;
    wr(`TBARM_CMD, 32'h4);
    arm_lvl <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    evt;
    chk(n_start, k);
    evt;
    chk(n_start, k + 1);
    k = n_stop;
    arm_lvl <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    chk(n_stop, k);
    arm_lvl <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    chk(n_stop, k + 1);
    wr(`TBARM_STOP_ECNT, 32'd3);
    wr(`TBARM_ARM_CFG, 32'h201);
    k = n_stop;
    wr(`TBARM_CMD, 32'h4);
    evt;
    evt;
    chk(n_stop, k);
    evt;
    repeat (10) @(posedge core_clk_i);
    chk(n_stop, k + 1);
    end_sim;
  end
endmodule // tbarm_top_test
